// ==== acfh_pkg.sv ====
package acfh_pkg;

  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] TYPE_TX64 = 8'h00;
  localparam logic [7:0] TYPE_LOCAL_CMD = 8'h08;
  localparam logic [7:0] TYPE_QUEUE_CMD = 8'h09;
  localparam logic [7:0] CSUM_GOOD = 8'hff;
  localparam logic [7:0] TX_OPT_NO_ACK = 8'h01;

  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_FRAME_ID = 16'h0004;
  localparam logic [15:0] OFS_CMD_HI = 16'h0005;
  localparam logic [15:0] OFS_CMD_LO = 16'h0006;
  localparam logic [15:0] OFS_VALUE_END = 16'h000b;
  localparam logic [15:0] OFS_TX_OPT = 16'h000d;
  localparam logic [15:0] OFS_TX_DATA = 16'h000e;

  localparam logic [15:0] TX_HDR_LEN = 16'h000b;
  localparam logic [15:0] MAX_TX_PAYLOAD = 16'h0576;
  localparam logic [15:0] FRAME_MAX_LEN = TX_HDR_LEN + MAX_TX_PAYLOAD;
  localparam logic [15:0] CMD_MIN_LEN = 16'h0004;

  localparam logic [15:0] CMD_APPLY = 16'h4143;
  localparam logic [15:0] CMD_SERIAL_RATE = 16'h4244;
  localparam logic [15:0] CMD_NODE_LABEL = 16'h4e49;

  localparam int PARAM_COUNT = 2;
  localparam logic [0:0] PARAM_SERIAL_RATE = 1'h0;
  localparam logic [0:0] PARAM_NODE_LABEL = 1'h1;
  localparam logic [31:0] SERIAL_RATE_RST = 32'h00000003;
  localparam logic [31:0] NODE_LABEL_RST = 32'h00000000;

  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_SLACK = 2;

  typedef enum logic [1:0] {
    APP_DATA = 2'b00,
    APP_END_OK = 2'b01,
    APP_END_BAD = 2'b10
  } acfh_app_kind_t;

  typedef struct packed {
    acfh_app_kind_t kind;
    logic [7:0] data;
  } acfh_app_word_t;

  typedef enum logic [2:0] {
    STAT_OK = 3'b000,
    STAT_CSUM = 3'b001,
    STAT_MALFORMED = 3'b010,
    STAT_TOO_LONG = 3'b011,
    STAT_BAD_OPTION = 3'b100,
    STAT_BAD_CMD = 3'b101
  } acfh_status_t;

  typedef enum logic {
    RSP_PARAM = 1'b0,
    RSP_STATUS = 1'b1
  } acfh_rsp_kind_t;

  typedef struct packed {
    acfh_rsp_kind_t kind;
    acfh_status_t status;
    logic [7:0] frame_id;
    logic [15:0] cmd;
    logic [31:0] value;
  } acfh_rsp_t;

  typedef enum logic [2:0] {
    S_HUNT = 3'b000,
    S_LEN_HI = 3'b001,
    S_LEN_LO = 3'b010,
    S_BODY = 3'b011,
    S_CSUM = 3'b100,
    S_EXEC = 3'b101,
    S_READ = 3'b110
  } acfh_state_t;

  typedef struct packed {
    logic hit;
    logic [0:0] idx;
  } acfh_param_hit_t;

  function automatic acfh_param_hit_t acfh_param_lookup(input logic [15:0] cmd);
    acfh_param_hit_t res;
    res.hit = 1'b1;
    res.idx = PARAM_SERIAL_RATE;
    case (cmd)
      CMD_SERIAL_RATE: res.idx = PARAM_SERIAL_RATE;
      CMD_NODE_LABEL: res.idx = PARAM_NODE_LABEL;
      default: res.hit = 1'b0;
    endcase
    return res;
  endfunction : acfh_param_lookup

endpackage : acfh_pkg

// ==== acfh_fifo.sv ====
`timescale 1ns/1ps
module acfh_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32,
  parameter int SLACK = 0
) (
  input logic i_clk,
  input logic i_rst,
  input logic [WIDTH-1:0] i_in_data,
  input logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
  } acfh_fifo_regs_t;

  acfh_fifo_regs_t r_reg;
  acfh_fifo_regs_t r_next;
  logic push;
  logic load;

  always_comb begin
    r_next = r_reg;
    push = i_in_valid && (r_reg.count != (AW+1)'(DEPTH));
    load = (!r_reg.out_valid || i_out_ready) && (r_reg.count != '0);
    if (r_reg.out_valid && i_out_ready) begin
      r_next.out_valid = 1'b0;
    end
    if (load) begin
      r_next.out_data = r_reg.mem[r_reg.rptr];
      r_next.out_valid = 1'b1;
      r_next.rptr = r_reg.rptr + 1'b1;
    end
    if (push) begin
      r_next.mem[r_reg.wptr] = i_in_data;
      r_next.wptr = r_reg.wptr + 1'b1;
    end
    r_next.count = r_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // slack leaves room for words the source has already committed to
  assign o_in_ready = r_reg.count < (AW+1)'(DEPTH - SLACK);
  assign o_out_data = r_reg.out_data;
  assign o_out_valid = r_reg.out_valid;

endmodule : acfh_fifo

// ==== acfh_param_store.sv ====
`timescale 1ns/1ps
module acfh_param_store
  import acfh_pkg::*;
(
  input logic i_clk,
  input logic i_rst,
  input logic i_wr_en,
  input logic [0:0] i_wr_idx,
  input logic [31:0] i_wr_data,
  input logic i_apply,
  input logic i_rd_en,
  input logic [0:0] i_rd_idx,
  output logic [31:0] o_rd_data,
  output logic [31:0] o_serial_rate
);
  typedef struct packed {
    logic [PARAM_COUNT-1:0][31:0] active;
    logic [PARAM_COUNT-1:0][31:0] pending;
    logic [PARAM_COUNT-1:0] pend_valid;
    logic [31:0] rd_data;
  } acfh_store_regs_t;

  localparam acfh_store_regs_t STORE_RST = '{
    active: {NODE_LABEL_RST, SERIAL_RATE_RST},
    pending: '0,
    pend_valid: '0,
    rd_data: '0
  };

  acfh_store_regs_t r_reg;
  acfh_store_regs_t r_next;

  always_comb begin
    r_next = r_reg;
    for (int i = 0; i < PARAM_COUNT; i++) begin
      if (i_wr_en && (i_wr_idx == 1'(i))) begin
        r_next.pending[i] = i_wr_data;
        r_next.pend_valid[i] = 1'b1;
      end
      if (i_apply) begin
        if (i_wr_en && (i_wr_idx == 1'(i))) begin
          r_next.active[i] = i_wr_data;
        end else if (r_reg.pend_valid[i]) begin
          r_next.active[i] = r_reg.pending[i];
        end
        r_next.pend_valid[i] = 1'b0;
      end
    end
    // reads return the running value, never the queued one
    if (i_rd_en) begin
      r_next.rd_data = r_reg.active[i_rd_idx];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= STORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_rd_data = r_reg.rd_data;
  assign o_serial_rate = r_reg.active[PARAM_SERIAL_RATE];

endmodule : acfh_param_store

// ==== acfh_frame_handler.sv ====
`timescale 1ns/1ps
module acfh_frame_handler
  import acfh_pkg::*;
(
  input logic I_SYS_CLK,
  input logic I_SYS_RST,
  input logic [7:0] I_RX_DATA,
  input logic I_RX_VALID,
  output logic O_RX_READY,
  output acfh_app_word_t O_APP_WORD,
  output logic O_APP_VALID,
  input logic I_APP_READY,
  output logic O_RSP_VALID,
  output acfh_rsp_t O_RSP,
  output logic [31:0] O_SERIAL_RATE
);
  typedef struct packed {
    acfh_state_t state;
    logic [15:0] len;
    logic [15:0] rem;
    logic [15:0] pos;
    logic [7:0] sum;
    logic [7:0] ftype;
    logic [7:0] fid;
    logic fid_seen;
    logic [15:0] cmd;
    logic [31:0] value;
    logic opt_bad;
    acfh_status_t err;
    logic rx_ready;
    logic rsp_valid;
    acfh_rsp_t rsp;
  } acfh_regs_t;

  acfh_regs_t r_reg;
  acfh_regs_t r_next;

  logic take;
  logic [7:0] sum_now;
  logic [15:0] len_full;
  logic is_local;
  logic is_tx;
  logic tx_fault;
  logic quiet;
  logic report;
  acfh_param_hit_t lk;
  logic push_valid;
  acfh_app_word_t push_word;
  logic fifo_in_ready;
  logic wr_en;
  logic apply;
  logic rd_en;
  logic [31:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // frame parser and executor

  always_comb begin
    r_next = r_reg;
    take = I_RX_VALID && r_reg.rx_ready;
    sum_now = r_reg.sum + I_RX_DATA;
    len_full = {r_reg.len[15:8], I_RX_DATA};
    is_local = (r_reg.ftype == TYPE_LOCAL_CMD) || (r_reg.ftype == TYPE_QUEUE_CMD);
    is_tx = (r_reg.ftype == TYPE_TX64);
    tx_fault = (r_reg.len < TX_HDR_LEN) || r_reg.opt_bad;
    lk = acfh_param_lookup(r_reg.cmd);
    quiet = r_reg.fid_seen && (r_reg.fid == 8'h00);
    report = 1'b0;
    push_valid = 1'b0;
    push_word = '{kind: APP_DATA, data: I_RX_DATA};
    wr_en = 1'b0;
    apply = 1'b0;
    rd_en = 1'b0;
    r_next.rsp_valid = 1'b0;
    case (r_reg.state)
      S_HUNT: begin
        if (take && (I_RX_DATA == START_DELIM)) begin
          r_next.state = S_LEN_HI;
          r_next.ftype = TYPE_TX64;
          r_next.fid = 8'h00;
          r_next.fid_seen = 1'b0;
          r_next.cmd = 16'h0000;
          r_next.value = 32'h00000000;
          r_next.opt_bad = 1'b0;
          r_next.err = STAT_OK;
          r_next.sum = 8'h00;
        end
      end
      S_LEN_HI: begin
        if (take) begin
          r_next.len = {I_RX_DATA, 8'h00};
          r_next.state = S_LEN_LO;
        end
      end
      S_LEN_LO: begin
        if (take) begin
          r_next.len = len_full;
          r_next.rem = len_full;
          r_next.pos = OFS_TYPE;
          r_next.state = S_BODY;
          if (len_full == 16'h0000) begin
            r_next.err = STAT_MALFORMED;
            r_next.state = S_EXEC;
          end else if (len_full > FRAME_MAX_LEN) begin
            r_next.err = STAT_TOO_LONG;
            r_next.state = S_EXEC;
          end
        end
      end
      S_BODY: begin
        if (take) begin
          r_next.sum = sum_now;
          r_next.pos = r_reg.pos + 16'h0001;
          r_next.rem = r_reg.rem - 16'h0001;
          if (r_reg.rem == 16'h0001) begin
            r_next.state = S_CSUM;
          end
          if (r_reg.pos == OFS_TYPE) begin
            r_next.ftype = I_RX_DATA;
          end
          if (r_reg.pos == OFS_FRAME_ID) begin
            r_next.fid = I_RX_DATA;
            r_next.fid_seen = 1'b1;
          end
          if (is_local && (r_reg.pos == OFS_CMD_HI)) begin
            r_next.cmd[15:8] = I_RX_DATA;
          end
          if (is_local && (r_reg.pos == OFS_CMD_LO)) begin
            r_next.cmd[7:0] = I_RX_DATA;
          end
          if (is_local && (r_reg.pos > OFS_CMD_LO)) begin
            r_next.value = {r_reg.value[23:0], I_RX_DATA};
            if (r_reg.pos >= OFS_VALUE_END) begin
              r_next.err = STAT_MALFORMED;
            end
          end
          if (is_tx && (r_reg.pos == OFS_TX_OPT)) begin
            r_next.opt_bad = |(I_RX_DATA & ~TX_OPT_NO_ACK);
          end
          if (is_tx && (r_reg.pos >= OFS_TX_DATA)) begin
            push_valid = 1'b1;
          end
        end
      end
      S_CSUM: begin
        if (take) begin
          if (sum_now != CSUM_GOOD) begin
            r_next.err = STAT_CSUM;
          end
          if (is_tx) begin
            push_valid = 1'b1;
            if ((sum_now == CSUM_GOOD) && (r_reg.err == STAT_OK) && !tx_fault) begin
              push_word.kind = APP_END_OK;
            end else begin
              push_word.kind = APP_END_BAD;
            end
          end
          r_next.state = S_EXEC;
        end
      end
      S_EXEC: begin
        r_next.state = S_HUNT;
        r_next.rsp.frame_id = r_reg.fid;
        r_next.rsp.cmd = r_reg.cmd;
        r_next.rsp.value = 32'h00000000;
        r_next.rsp.kind = RSP_STATUS;
        r_next.rsp.status = STAT_OK;
        if (r_reg.err != STAT_OK) begin
          r_next.rsp.status = r_reg.err;
          report = 1'b1;
        end else if (is_tx) begin
          if (tx_fault) begin
            r_next.rsp.status = (r_reg.len < TX_HDR_LEN) ? STAT_MALFORMED : STAT_BAD_OPTION;
            report = 1'b1;
          end
        end else if (is_local) begin
          r_next.rsp.kind = RSP_PARAM;
          if (r_reg.len < CMD_MIN_LEN) begin
            r_next.rsp.kind = RSP_STATUS;
            r_next.rsp.status = STAT_MALFORMED;
            report = 1'b1;
          end else if (r_reg.cmd == CMD_APPLY) begin
            apply = 1'b1;
            report = 1'b1;
          end else if (!lk.hit) begin
            r_next.rsp.kind = RSP_STATUS;
            r_next.rsp.status = STAT_BAD_CMD;
            report = 1'b1;
          end else if (r_reg.len > CMD_MIN_LEN) begin
            wr_en = 1'b1;
            apply = (r_reg.ftype == TYPE_LOCAL_CMD);
            report = 1'b1;
          end else begin
            rd_en = 1'b1;
            r_next.state = S_READ;
          end
        end
        r_next.rsp_valid = report && !quiet;
      end
      S_READ: begin
        r_next.rsp.value = rd_data;
        r_next.rsp_valid = !quiet;
        r_next.state = S_HUNT;
      end
      default: begin
        r_next.state = S_HUNT;
      end
    endcase
    r_next.rx_ready = fifo_in_ready && (r_next.state != S_EXEC) && (r_next.state != S_READ);
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign O_RX_READY = r_reg.rx_ready;
  assign O_RSP_VALID = r_reg.rsp_valid;
  assign O_RSP = r_reg.rsp;

  ////////////////////////////////////////////////////////////////////////////
  // payload buffer and parameter store

  acfh_fifo #(
    .WIDTH($bits(acfh_app_word_t)),
    .DEPTH(FIFO_DEPTH),
    .SLACK(FIFO_SLACK)
  ) u_app_fifo (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_in_data(push_word),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_in_ready),
    .o_out_data(O_APP_WORD),
    .o_out_valid(O_APP_VALID),
    .i_out_ready(I_APP_READY)
  );

  acfh_param_store u_params (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_wr_en(wr_en),
    .i_wr_idx(lk.idx),
    .i_wr_data(r_reg.value),
    .i_apply(apply),
    .i_rd_en(rd_en),
    .i_rd_idx(lk.idx),
    .o_rd_data(rd_data),
    .o_serial_rate(O_SERIAL_RATE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  property p_hunt_ignore;
    (r_reg.state == S_HUNT) && take && (I_RX_DATA != START_DELIM) |=> (r_reg.state == S_HUNT);
  endproperty
  a_hunt_ignore: assert property (p_hunt_ignore) else $error("stray byte left hunt");

  property p_len_msb;
    (r_reg.state == S_LEN_HI) && take |=> (r_reg.len[15:8] == $past(I_RX_DATA));
  endproperty
  a_len_msb: assert property (p_len_msb) else $error("length high byte lost");

  property p_csum_bad;
    (r_reg.state == S_CSUM) && take && (sum_now != CSUM_GOOD) && !quiet
      |-> ##2 (O_RSP_VALID && (O_RSP.status == STAT_CSUM));
  endproperty
  a_csum_bad: assert property (p_csum_bad) else $error("checksum fault not reported");

  property p_payload_push;
    (r_reg.state == S_BODY) && take && is_tx && (r_reg.pos >= OFS_TX_DATA)
      |-> push_valid && (push_word.kind == APP_DATA);
  endproperty
  a_payload_push: assert property (p_payload_push) else $error("payload byte not queued");

  property p_bad_opt;
    (r_reg.state == S_CSUM) && take && is_tx && r_reg.opt_bad && (sum_now == CSUM_GOOD)
      && (r_reg.err == STAT_OK) && (r_reg.len >= TX_HDR_LEN) && !quiet
      |-> ##2 (O_RSP_VALID && (O_RSP.status == STAT_BAD_OPTION));
  endproperty
  a_bad_opt: assert property (p_bad_opt) else $error("bad option not reported");

  property p_too_long;
    (r_reg.state == S_LEN_LO) && take && (len_full > FRAME_MAX_LEN) |=> (r_reg.state == S_EXEC) ##1 (r_reg.state == S_HUNT);
  endproperty
  a_too_long: assert property (p_too_long) else $error("oversize frame accepted");

  property p_apply_local;
    (r_reg.state == S_EXEC) && wr_en && (r_reg.ftype == TYPE_LOCAL_CMD)
      && (lk.idx == PARAM_SERIAL_RATE) |=> (O_SERIAL_RATE == $past(r_reg.value));
  endproperty
  a_apply_local: assert property (p_apply_local) else $error("apply mismatch on write");

  property p_rate_hold;
    (r_reg.state == S_EXEC) && wr_en && !apply |=> $stable(O_SERIAL_RATE);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("queued rate took effect");

  property p_fid_quiet;
    (r_reg.state == S_EXEC) && quiet |=> !O_RSP_VALID [*2];
  endproperty
  a_fid_quiet: assert property (p_fid_quiet) else $error("answer sent for zero id");

  property p_unknown_type;
    (r_reg.state == S_EXEC) && !is_local && !is_tx |-> !wr_en && !apply && !rd_en;
  endproperty
  a_unknown_type: assert property (p_unknown_type) else $error("unknown type touched params");

  property p_short_cmd;
    (r_reg.state == S_EXEC) && is_local && (r_reg.len < CMD_MIN_LEN) |-> !wr_en && !apply;
  endproperty
  a_short_cmd: assert property (p_short_cmd) else $error("short command executed");

endmodule : acfh_frame_handler

// ==== acfh_host_model.sv ====
`timescale 1ns/1ps
module acfh_host_model
  import acfh_pkg::*;
(
  input logic i_clk,
  input logic i_rst,
  input logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid
);
  logic [7:0] byte_q[$];
  integer seed = 32'hb386083e;

  initial begin
    o_data = 8'h00;
    o_valid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // byte source with random gaps; idle data keeps toggling
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
    end else if (!o_valid || i_ready) begin
      if (byte_q.size() != 0 && ($random(seed) % 4 != 0)) begin
        o_data <= byte_q.pop_front();
        o_valid <= 1'b1;
      end else begin
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // length high byte first, then checksum
  task automatic send_frame(input logic [7:0] body[$], input bit bad);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    byte_q.push_back(START_DELIM);
    byte_q.push_back(8'(body.size() >> 8));
    byte_q.push_back(8'(body.size()));
    foreach (body[i]) byte_q.push_back(body[i]);
    byte_q.push_back((CSUM_GOOD - sum) ^ {7'h00, bad});
  endtask : send_frame
endmodule : acfh_host_model

// ==== api_command_frame_handler_bench.sv ====
`timescale 1ns/1ps
module api_command_frame_handler_bench;
  import acfh_pkg::*;
  logic I_SYS_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic I_APP_READY = 1'b0;
  logic [7:0] rx_data;
  logic rx_valid, rx_ready, app_valid, rsp_valid;
  acfh_app_word_t app_word, app_e;
  acfh_rsp_t rsp, rsp_e;
  logic [31:0] rate;
  acfh_rsp_t rsp_q[$];
  acfh_app_word_t app_q[$];
  int bad_count = 0;
  int checks_done = 0;
  integer seed = 32'hb386083e;
  bit stall = 1'b0;

  always #12.5 I_SYS_CLK = ~I_SYS_CLK;

  acfh_frame_handler uut (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_RX_DATA(rx_data),
    .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready), .O_APP_WORD(app_word),
    .O_APP_VALID(app_valid), .I_APP_READY(I_APP_READY), .O_RSP_VALID(rsp_valid),
    .O_RSP(rsp), .O_SERIAL_RATE(rate));
  acfh_host_model host (.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST), .i_ready(rx_ready),
    .o_data(rx_data), .o_valid(rx_valid));

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // app sink and result monitors
  always @(posedge I_SYS_CLK) I_APP_READY <= !stall && ($random(seed) % 3 != 0);

  always @(posedge I_SYS_CLK) begin
    if (!I_SYS_RST && rsp_valid === 1'b1) begin
      if (rsp_q.size() == 0) begin
        check("rsp_extra", 1'b1, 1'b0);
      end else begin
        rsp_e = rsp_q.pop_front();
        if (rsp_e.kind == RSP_STATUS) check("status", rsp[59:48], rsp_e[59:48]);
        else check("param_rsp", rsp, rsp_e);
      end
    end
    if (!I_SYS_RST && app_valid === 1'b1 && I_APP_READY === 1'b1) begin
      if (app_q.size() == 0) begin
        check("app_extra", 1'b1, 1'b0);
      end else begin
        app_e = app_q.pop_front();
        check("app_word", app_word, app_e);
      end
    end
  end

  function automatic acfh_rsp_t er(acfh_rsp_kind_t k, acfh_status_t s, logic [7:0] f,
      logic [15:0] c, logic [31:0] v);
    return '{kind: k, status: s, frame_id: f, cmd: c, value: v};
  endfunction : er

  task automatic settle;
    int n;
    n = 0;
    while ((host.byte_q.size() != 0 || rx_valid || rsp_q.size() != 0 || app_q.size() != 0)
        && n < 4000) begin
      @(posedge I_SYS_CLK);
      n++;
    end
    if (n >= 4000) check("settle", 1'b0, 1'b1);
    repeat (6) @(posedge I_SYS_CLK);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  // transmit request, address in low 32 bits
  task automatic tx(input logic [7:0] fid, input logic [7:0] opt, input int n);
    logic [7:0] b[$];
    logic [7:0] d;
    logic [7:0] s;
    b = '{8'h00, fid, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00, 8'h64, opt};
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      b.push_back(d);
      app_q.push_back('{kind: APP_DATA, data: d});
    end
    // end word carries the checksum byte the host sends
    s = 8'h00;
    foreach (b[i]) s += b[i];
    app_q.push_back('{kind: (opt == 8'h00 || opt == TX_OPT_NO_ACK) ? APP_END_OK : APP_END_BAD,
      data: CSUM_GOOD - s});
    host.send_frame(b, 1'b0);
  endtask : tx

  initial begin
    #(25 * 60000);
    check("watchdog", 1'b0, 1'b1);
    test_done();
  end

  initial begin
    repeat (12) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    @(negedge I_SYS_CLK);
    check("rate_rst", rate, SERIAL_RATE_RST);
    check("rsp_valid_rst", rsp_valid, 1'b0);
    check("app_valid_rst", app_valid, 1'b0);
    host.byte_q = '{8'h11, 8'h22, 8'h7d};
    host.send_frame('{8'h08, 8'h01, 8'h42, 8'h44, 8'h08}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h01, CMD_SERIAL_RATE, 32'h0));
    settle();
    check("rate_set", rate, 32'h8);
    host.send_frame('{8'h08, 8'h02, 8'h42, 8'h44}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h02, CMD_SERIAL_RATE, 32'h8));
    host.send_frame('{8'h09, 8'h03, 8'h42, 8'h44, 8'h00, 8'h07}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h03, CMD_SERIAL_RATE, 32'h0));
    settle();
    check("rate_pending", rate, 32'h8);
    // queued read answered with running value
    host.send_frame('{8'h09, 8'h04, 8'h42, 8'h44}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h04, CMD_SERIAL_RATE, 32'h8));
    host.send_frame('{8'h08, 8'h05, 8'h41, 8'h43}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h05, CMD_APPLY, 32'h0));
    settle();
    check("rate_applied", rate, 32'h7);
    host.send_frame('{8'h08, 8'h06, 8'h4e, 8'h49, 8'h00, 8'h00, 8'h00, 8'h05}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h06, CMD_NODE_LABEL, 32'h0));
    host.send_frame('{8'h08, 8'h07, 8'h4e, 8'h49}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h07, CMD_NODE_LABEL, 32'h5));
    host.send_frame('{8'h08, 8'h08, 8'h42, 8'h44, 8'h01}, 1'b1);
    rsp_q.push_back(er(RSP_STATUS, STAT_CSUM, 8'h08, 16'h0, 32'h0));
    settle();
    check("rate_csum", rate, 32'h7);
    host.send_frame('{8'h08, 8'h00, 8'h42, 8'h44, 8'h02}, 1'b0);
    host.send_frame('{8'h33, 8'h09, 8'h42, 8'h44, 8'h09}, 1'b0);
    settle();
    check("rate_silent", rate, 32'h2);
    host.send_frame('{8'h08, 8'h0a, 8'h42}, 1'b0);
    rsp_q.push_back(er(RSP_STATUS, STAT_MALFORMED, 8'h0a, 16'h0, 32'h0));
    host.send_frame('{8'h08, 8'h0b, 8'h5a, 8'h5a}, 1'b0);
    rsp_q.push_back(er(RSP_STATUS, STAT_BAD_CMD, 8'h0b, 16'h0, 32'h0));
    settle();
    stall = 1'b1;
    tx(8'h0c, TX_OPT_NO_ACK, 40);
    repeat (150) @(posedge I_SYS_CLK);
    check("backpressure", {rx_ready, app_valid}, 2'b01);
    stall = 1'b0;
    tx(8'h0d, 8'h02, 3);
    rsp_q.push_back(er(RSP_STATUS, STAT_BAD_OPTION, 8'h0d, 16'h0, 32'h0));
    settle();
    // length beyond payload limit, then hunt
    host.byte_q = '{8'h7e, 8'h05, 8'h82, 8'h55};
    rsp_q.push_back(er(RSP_STATUS, STAT_TOO_LONG, 8'h00, 16'h0, 32'h0));
    host.send_frame('{8'h08, 8'h0e, 8'h42, 8'h44}, 1'b0);
    rsp_q.push_back(er(RSP_PARAM, STAT_OK, 8'h0e, CMD_SERIAL_RATE, 32'h2));
    settle();
    test_done();
  end
endmodule : api_command_frame_handler_bench
